// ==== pkg/regulator_pkg.sv ====
package regulator_pkg;

    // register indexes; byte address is four times the index
    localparam int             ADDR_W      = 10;
    localparam logic [7:0]     CTRL_IDX    = 8'hc9;
    localparam logic [7:0]     STATUS_IDX  = 8'hca;
    localparam logic [7:0]     MASK_IDX    = 8'hcb;
    localparam logic [7:0]     STATE_IDX   = 8'hcc;

    // regulator control fields
    localparam int             BIT_PRI_DIS = 7;
    localparam int             BIT_LINE    = 6;
    localparam int             BIT_PRI_LP  = 4;
    localparam int             BIT_STOP_SD = 3;
    localparam int             BIT_CORE_LP = 1;
    localparam logic [7:0]     CTRL_RST    = 8'h00;
    localparam logic [7:0]     CTRL_WMASK  = 8'hbf;

    // sticky event bits, shared by status and mask
    localparam int             EV_W        = 3;
    localparam int             EV_STOP_IN  = 0;
    localparam int             EV_WAKE     = 1;
    localparam int             EV_MISUSE   = 2;
    localparam logic [EV_W-1:0] EV_RST     = 3'h0;

    // live state bits
    localparam int             ST_IN_STOP  = 0;
    localparam int             ST_SHUTDOWN = 1;
    localparam int             ST_OSC_OK   = 2;

    // instruction clocks between core low power and oscillator suspend
    localparam int             LP_SETTLE_CLKS = 12;
    localparam int             SETTLE_W       = 4;

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_STOP_ON,
        PWR_STOP_OFF
    } pwr_state_t;

    typedef struct packed {
        logic primary_en;
        logic primary_lp;
        logic core_en;
        logic core_lp;
        logic supply_en;
    } regulator_drive_t;

    localparam regulator_drive_t DRIVE_RST = regulator_drive_t'(5'h15);

endpackage

// ==== tb/regulator_power_control_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module regulator_power_control_tb_top;
    logic                            mclk;
    logic                            nrst;
    logic                            read;
    logic                            write;
    logic                            line;
    logic                            line_en;
    logic                            stop_req;
    logic                            rst_pin_n;
    logic [9:0]                      address;
    logic [31:0]                     writedata;
    logic [31:0]                     readdata;
    logic [31:0]                     rd;
    logic [3:0]                      byteenable;
    logic [3:0]                      reset_src;
    logic                            waitrequest;
    logic                            in_stop;
    logic                            device_reset;
    logic                            line_two_irq;
    logic                            irq;
    regulator_pkg::regulator_drive_t drive;
    int                              bad_count;
    int                              comparisons;
    int                              cycles;
    logic [7:0]                      lf;
    logic [7:0]                      wv;

    regulator_power_control #(.RESET_SRC_W(4)) uut (
        .mclk                        (mclk),
        .nrst                        (nrst),
        .address                     (address),
        .read                        (read),
        .write                       (write),
        .writedata                   (writedata),
        .byteenable                  (byteenable),
        .readdata                    (readdata),
        .waitrequest                 (waitrequest),
        .external_interrupt_line_two (line),
        .line_two_int_en             (line_en),
        .stop_req                    (stop_req),
        .reset_src                   (reset_src),
        .rst_pin_n                   (rst_pin_n),
        .drive                       (drive),
        .in_stop                     (in_stop),
        .device_reset                (device_reset),
        .line_two_irq                (line_two_irq),
        .irq                         (irq)
    );

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // control readback: writable bits plus live line level
    function automatic logic [31:0] exp_ctrl(input logic [7:0] w, input logic l);
        return {24'h0, (w & regulator_pkg::CTRL_WMASK) | {1'b0, l, 6'h00}};
    endfunction

    // regulator drive from control bits and stop state
    function automatic logic [4:0] exp_drive(input logic [7:0] c, input logic stp);
        logic off;
        off = stp & c[regulator_pkg::BIT_STOP_SD];
        return {~c[regulator_pkg::BIT_PRI_DIS], c[regulator_pkg::BIT_PRI_LP], ~off,
                c[regulator_pkg::BIT_CORE_LP], ~off};
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       input logic [3:0] be);
        @(posedge mclk);
        address <= {idx, 2'b00};
        read <= ~wr;
        write <= wr;
        writedata <= wd;
        byteenable <= be;
        @(posedge mclk);
        while (waitrequest !== 1'b0) @(posedge mclk);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    initial begin
        {nrst, read, write, line, line_en, stop_req} = 6'h00;
        rst_pin_n = 1'b1;
        address = 10'h000;
        writedata = 32'h0;
        byteenable = 4'h0;
        reset_src = 4'h0;
        lf = 8'h19;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        check("drive_rst", drive, regulator_pkg::DRIVE_RST);
        check("wait_rst", waitrequest, 1'b1);
        check("irq_rst", irq, 1'b0);
        bus(1'b0, regulator_pkg::CTRL_IDX, 32'h0, 4'hf);
        check("ctrl_rst", rd, regulator_pkg::CTRL_RST);
        // random control values and line levels
        for (int i = 0; i < 12; i++) begin
            lf = lfsr(lf);
            wv = lf[7] ? (lf & 8'hfd) : lf;
            line <= lf[2];
            bus(1'b1, regulator_pkg::CTRL_IDX, {24'h0, wv}, 4'hf);
            @(posedge mclk);
            check("drive", drive, exp_drive(wv, 1'b0));
            bus(1'b0, regulator_pkg::CTRL_IDX, 32'h0, 4'hf);
            check("ctrl", rd, exp_ctrl(wv, line));
        end
        bus(1'b1, regulator_pkg::CTRL_IDX, 32'h92, 4'he);
        bus(1'b0, regulator_pkg::CTRL_IDX, 32'h0, 4'hf);
        check("ctrl_lane_off", rd, exp_ctrl(wv, line));
        bus(1'b0, 8'h10, 32'h0, 4'hf);
        check("unmapped", rd, 32'h0);
        // misuse event, mask, level irq, write one clear
        bus(1'b1, regulator_pkg::STATUS_IDX, 32'h7, 4'hf);
        bus(1'b1, regulator_pkg::CTRL_IDX, 32'h82, 4'hf);
        bus(1'b0, regulator_pkg::STATUS_IDX, 32'h0, 4'hf);
        check("status_misuse", rd, 32'h1 << regulator_pkg::EV_MISUSE);
        check("irq_masked", irq, 1'b0);
        bus(1'b1, regulator_pkg::MASK_IDX, 32'h7, 4'hf);
        @(posedge mclk);
        check("irq_on", irq, 1'b1);
        bus(1'b1, regulator_pkg::STATUS_IDX, 32'h4, 4'hf);
        @(posedge mclk);
        check("irq_off", irq, 1'b0);
        bus(1'b0, regulator_pkg::MASK_IDX, 32'h0, 4'hf);
        check("mask", rd, 32'h7);
        // settle guard after core low power
        bus(1'b1, regulator_pkg::CTRL_IDX, 32'h00, 4'hf);
        bus(1'b1, regulator_pkg::CTRL_IDX, 32'h02, 4'hf);
        bus(1'b0, regulator_pkg::STATE_IDX, 32'h0, 4'hf);
        check("settle_early", rd[regulator_pkg::ST_OSC_OK], 1'b0);
        repeat (14) @(posedge mclk);
        bus(1'b0, regulator_pkg::STATE_IDX, 32'h0, 4'hf);
        check("settle_done", rd[regulator_pkg::ST_OSC_OK], 1'b1);
        // line two edges, enabled then disabled
        for (int i = 0; i < 6; i++) begin
            @(posedge mclk);
            line_en <= (i < 4);
            line <= ~line;
            @(posedge mclk);
            @(posedge mclk);
            check("line_pulse", line_two_irq, i < 4);
            @(posedge mclk);
            check("line_drop", line_two_irq, 1'b0);
        end
        // stop with core kept up, then with shutdown
        for (int m = 0; m < 2; m++) begin
            wv = m ? 8'h08 : 8'h00;
            bus(1'b1, regulator_pkg::CTRL_IDX, {24'h0, wv}, 4'hf);
            bus(1'b1, regulator_pkg::STATUS_IDX, 32'h7, 4'hf);
            stop_req <= 1'b1;
            @(posedge mclk);
            stop_req <= 1'b0;
            @(posedge mclk);
            check("in_stop", in_stop, 1'b1);
            check("drive_stop", drive, exp_drive(wv, 1'b1));
            check("irq_stop", irq, 1'b1);
            reset_src <= 4'hf;
            @(posedge mclk);
            @(posedge mclk);
            check("src_reset", device_reset, m == 0);
            check("src_wake", in_stop, m == 1);
            reset_src <= 4'h0;
            rst_pin_n <= 1'b0;
            @(posedge mclk);
            @(posedge mclk);
            check("pin_reset", device_reset, 1'b1);
            check("pin_wake", in_stop, 1'b0);
            check("drive_wake", drive, exp_drive(wv, 1'b0));
            rst_pin_n <= 1'b1;
            bus(1'b0, regulator_pkg::STATUS_IDX, 32'h0, 4'hf);
            check("status_stop", rd, 32'h3);
        end
        give_verdict();
    end
endmodule

`default_nettype wire

// ==== verilog/ext_line_two_edge.sv ====
`timescale 1ns/1ps
`default_nettype none

module ext_line_two_edge (
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic line,
    input  wire logic int_en,
    output var  logic edge_irq_r
);

    logic line_q_r;
    logic primed_r;
    wire  line_edge = primed_r && (line != line_q_r);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            line_q_r   <= 1'b0;
            primed_r   <= 1'b0;
            edge_irq_r <= 1'b0;
        end else begin
            line_q_r   <= line;
            primed_r   <= 1'b1;
            edge_irq_r <= int_en && line_edge;
        end
    end

    both_edges_a: assert property (@(posedge mclk) disable iff (!nrst)
        (int_en && primed_r && $changed(line)) |=> edge_irq_r)
        else $error("line two edge gave no interrupt");

    no_pending_a: assert property (@(posedge mclk) disable iff (!nrst)
        !int_en |=> !edge_irq_r)
        else $error("line two interrupt held without enable");

    no_edge_a: assert property (@(posedge mclk) disable iff (!nrst)
        (primed_r && !$changed(line)) |=> !edge_irq_r)
        else $error("line two interrupt without an edge");

endmodule

`default_nettype wire

// ==== verilog/regulator_power_control.sv ====
`timescale 1ns/1ps
`default_nettype none

module regulator_power_control #(
    parameter int RESET_SRC_W = 4
) (
    input  wire logic                              mclk,
    input  wire logic                              nrst,
    input  wire logic [regulator_pkg::ADDR_W-1:0]  address,
    input  wire logic                              read,
    input  wire logic                              write,
    input  wire logic [31:0]                       writedata,
    input  wire logic [3:0]                        byteenable,
    output var  logic [31:0]                       readdata,
    output var  logic                              waitrequest,
    input  wire logic                              external_interrupt_line_two,
    input  wire logic                              line_two_int_en,
    input  wire logic                              stop_req,
    input  wire logic [RESET_SRC_W-1:0]            reset_src,
    input  wire logic                              rst_pin_n,
    output var  regulator_pkg::regulator_drive_t   drive,
    output var  logic                              in_stop,
    output var  logic                              device_reset,
    output var  logic                              line_two_irq,
    output var  logic                              irq
);

    if (RESET_SRC_W < 1 || RESET_SRC_W > 16) begin : bad_reset_src_w
        $error("RESET_SRC_W must lie between 1 and 16");
    end

    // bus state
    logic                            waitrequest_r;
    logic [31:0]                     readdata_r;

    // registers
    logic [7:0]                      ctrl_r;
    logic [regulator_pkg::EV_W-1:0]  status_r;
    logic [regulator_pkg::EV_W-1:0]  mask_r;
    logic [regulator_pkg::SETTLE_W-1:0] settle_r;
    regulator_pkg::pwr_state_t       state_r;
    regulator_pkg::regulator_drive_t drive_r;
    logic                            in_stop_r;
    logic                            device_reset_r;
    logic                            irq_r;

    // next values
    logic [7:0]                      ctrl_nxt;
    logic [regulator_pkg::EV_W-1:0]  status_nxt;
    logic [regulator_pkg::EV_W-1:0]  mask_nxt;
    logic [regulator_pkg::SETTLE_W-1:0] settle_nxt;
    regulator_pkg::pwr_state_t       state_nxt;
    regulator_pkg::regulator_drive_t drive_nxt;
    logic [31:0]                     rdata_nxt;

    // address decode
    wire        req        = read || write;
    wire        accept     = req && !waitrequest_r;
    wire        lane0      = byteenable[0];
    wire [7:0]  word_idx   = address[regulator_pkg::ADDR_W-1:2];
    wire        hit_ctrl   = (word_idx == regulator_pkg::CTRL_IDX);
    wire        hit_status = (word_idx == regulator_pkg::STATUS_IDX);
    wire        hit_mask   = (word_idx == regulator_pkg::MASK_IDX);
    wire        hit_state  = (word_idx == regulator_pkg::STATE_IDX);
    wire        wr_ctrl    = accept && write && lane0 && hit_ctrl;
    wire        wr_status  = accept && write && lane0 && hit_status;
    wire        wr_mask    = accept && write && lane0 && hit_mask;

    // control fields
    wire        pri_dis    = ctrl_r[regulator_pkg::BIT_PRI_DIS];
    wire        pri_lp     = ctrl_r[regulator_pkg::BIT_PRI_LP];
    wire        stop_sd    = ctrl_r[regulator_pkg::BIT_STOP_SD];
    wire        core_lp    = ctrl_r[regulator_pkg::BIT_CORE_LP];

    // control register write; line level bit is never stored
    wire [7:0]  ctrl_wr_val = writedata[7:0] & regulator_pkg::CTRL_WMASK;
    assign ctrl_nxt = wr_ctrl ? ctrl_wr_val : ctrl_r;

    // live level of line two for the read mux
    wire [7:0]  ctrl_rd_val;
    assign ctrl_rd_val = {ctrl_r[7],
                          external_interrupt_line_two,
                          ctrl_r[5:0]};

    // oscillator suspend guard: counts instruction clocks in core low power
    wire        osc_ok     = (settle_r == regulator_pkg::SETTLE_W'(regulator_pkg::LP_SETTLE_CLKS));
    assign settle_nxt = !core_lp ? '0 :
                        osc_ok   ? settle_r :
                                   settle_r + regulator_pkg::SETTLE_W'(1);

    // stop mode sequencing
    wire        any_src    = |reset_src;
    wire        pin_reset  = !rst_pin_n;
    wire        wake       = (state_r == regulator_pkg::PWR_STOP_ON  && any_src) ||
                             (state_r != regulator_pkg::PWR_RUN      && pin_reset);
    wire        reset_nxt  = pin_reset ||
                             (state_r != regulator_pkg::PWR_STOP_OFF && any_src);
    wire        enter_stop = (state_r == regulator_pkg::PWR_RUN) && stop_req && !reset_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            regulator_pkg::PWR_RUN: begin
                if (enter_stop) begin
                    state_nxt = stop_sd ? regulator_pkg::PWR_STOP_OFF
                                        : regulator_pkg::PWR_STOP_ON;
                end
            end
            regulator_pkg::PWR_STOP_ON: begin
                if (wake) begin
                    state_nxt = regulator_pkg::PWR_RUN;
                end
            end
            regulator_pkg::PWR_STOP_OFF: begin
                if (wake) begin
                    state_nxt = regulator_pkg::PWR_RUN;
                end
            end
            default: begin
                state_nxt = regulator_pkg::PWR_RUN;
            end
        endcase
    end

    // regulator drive, taken from the next control and state values
    wire        nxt_off    = (state_nxt == regulator_pkg::PWR_STOP_OFF);
    assign drive_nxt.primary_en = !ctrl_nxt[regulator_pkg::BIT_PRI_DIS];
    assign drive_nxt.primary_lp = ctrl_nxt[regulator_pkg::BIT_PRI_LP];
    assign drive_nxt.core_en    = !nxt_off;
    assign drive_nxt.core_lp    = ctrl_nxt[regulator_pkg::BIT_CORE_LP];
    assign drive_nxt.supply_en  = !nxt_off;

    // events: stop entry, wake, core low power misuse
    wire        misuse_now = ctrl_nxt[regulator_pkg::BIT_CORE_LP] &&
                             ctrl_nxt[regulator_pkg::BIT_PRI_DIS];
    wire        misuse_ev  = wr_ctrl && misuse_now;
    wire [regulator_pkg::EV_W-1:0] ev_set;
    assign ev_set[regulator_pkg::EV_STOP_IN] = enter_stop;
    assign ev_set[regulator_pkg::EV_WAKE]    = wake;
    assign ev_set[regulator_pkg::EV_MISUSE]  = misuse_ev;

    // write one to clear; a new event wins over the clear
    wire [regulator_pkg::EV_W-1:0] ev_clr;
    assign ev_clr     = wr_status ? writedata[regulator_pkg::EV_W-1:0] : '0;
    assign status_nxt = (status_r & ~ev_clr) | ev_set;
    assign mask_nxt   = wr_mask ? writedata[regulator_pkg::EV_W-1:0] : mask_r;
    wire   irq_nxt    = |(status_nxt & mask_nxt);

    // read mux; unmapped words read as zero
    wire [7:0] state_rd_val;
    assign state_rd_val = {5'h0, osc_ok, stop_sd, in_stop_r};
    assign rdata_nxt = hit_ctrl   ? {24'h000000, ctrl_rd_val} :
                       hit_status ? {29'h0, status_r} :
                       hit_mask   ? {29'h0, mask_r} :
                       hit_state  ? {24'h000000, state_rd_val} :
                                    32'h00000000;

    // bus handshake: one wait cycle, then the answer for one cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            waitrequest_r <= 1'b1;
            readdata_r    <= 32'h00000000;
        end else begin
            waitrequest_r <= !(req && waitrequest_r);
            if (req && waitrequest_r) begin
                readdata_r <= read ? rdata_nxt : 32'h00000000;
            end
        end
    end

    // register and sequencer state
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r   <= regulator_pkg::CTRL_RST;
            status_r <= regulator_pkg::EV_RST;
            mask_r   <= regulator_pkg::EV_RST;
            settle_r <= '0;
            state_r  <= regulator_pkg::PWR_RUN;
        end else begin
            ctrl_r   <= ctrl_nxt;
            status_r <= status_nxt;
            mask_r   <= mask_nxt;
            settle_r <= settle_nxt;
            state_r  <= state_nxt;
        end
    end

    // registered outputs
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            drive_r        <= regulator_pkg::DRIVE_RST;
            in_stop_r      <= 1'b0;
            device_reset_r <= 1'b0;
            irq_r          <= 1'b0;
        end else begin
            drive_r        <= drive_nxt;
            in_stop_r      <= (state_nxt != regulator_pkg::PWR_RUN);
            device_reset_r <= reset_nxt;
            irq_r          <= irq_nxt;
        end
    end

    ext_line_two_edge line_two (
        .mclk       (mclk),
        .nrst       (nrst),
        .line       (external_interrupt_line_two),
        .int_en     (line_two_int_en),
        .edge_irq_r (line_two_irq)
    );

    assign readdata     = readdata_r;
    assign waitrequest  = waitrequest_r;
    assign drive        = drive_r;
    assign in_stop      = in_stop_r;
    assign device_reset = device_reset_r;
    assign irq          = irq_r;

    // checks
    sequence ctrl_write_s;
        !waitrequest_r && write && byteenable[0] && hit_ctrl;
    endsequence

    sequence stop_entry_s;
        state_r == regulator_pkg::PWR_RUN && stop_req && !reset_nxt;
    endsequence

    sequence stop_on_s;
        state_r == regulator_pkg::PWR_STOP_ON;
    endsequence

    sequence stop_off_s;
        state_r == regulator_pkg::PWR_STOP_OFF;
    endsequence

    pri_disable_a: assert property (@(posedge mclk) disable iff (!nrst)
        ctrl_write_s |=> drive_r.primary_en == !$past(writedata[7]))
        else $error("primary enable does not follow its control bit");

    pri_bit7_a: assert property (@(posedge mclk) disable iff (!nrst)
        (!waitrequest_r && read && hit_ctrl) |->
        readdata_r[regulator_pkg::BIT_PRI_DIS] == !drive_r.primary_en)
        else $error("primary disable not at bit 7");

    pri_mode_a: assert property (@(posedge mclk) disable iff (!nrst)
        ctrl_write_s |=> drive_r.primary_lp == $past(writedata[4]) ##1
        drive_r.primary_lp == ctrl_r[4])
        else $error("primary mode does not follow its control bit");

    pri_bit4_a: assert property (@(posedge mclk) disable iff (!nrst)
        (!waitrequest_r && read && hit_ctrl) |->
        readdata_r[regulator_pkg::BIT_PRI_LP] == drive_r.primary_lp)
        else $error("primary mode not at bit 4");

    core_mode_a: assert property (@(posedge mclk) disable iff (!nrst)
        ctrl_write_s |=> drive_r.core_lp == $past(writedata[1]))
        else $error("core mode does not follow its control bit");

    core_bit1_a: assert property (@(posedge mclk) disable iff (!nrst)
        (!waitrequest_r && read && hit_ctrl) |->
        readdata_r[regulator_pkg::BIT_CORE_LP] == drive_r.core_lp)
        else $error("core mode not at bit 1");

    line_level_a: assert property (@(posedge mclk) disable iff (!nrst)
        (!waitrequest_r && read && hit_ctrl) |->
        readdata_r[6] == $past(external_interrupt_line_two))
        else $error("line two level read back wrong");

    stop_keep_a: assert property (@(posedge mclk) disable iff (!nrst)
        (stop_entry_s ##0 !stop_sd) |=> in_stop_r && drive_r.core_en && drive_r.supply_en)
        else $error("core regulator dropped in stop without shutdown");

    keep_wake_a: assert property (@(posedge mclk) disable iff (!nrst)
        (stop_on_s ##0 any_src) |=> device_reset_r && !in_stop_r)
        else $error("reset source failed to wake from stop");

    shut_down_a: assert property (@(posedge mclk) disable iff (!nrst)
        (stop_entry_s ##0 stop_sd) |=> in_stop_r && !drive_r.core_en && !drive_r.supply_en)
        else $error("core regulator kept up in shutdown stop");

    shut_ignore_a: assert property (@(posedge mclk) disable iff (!nrst)
        (stop_off_s ##0 rst_pin_n) |=> !device_reset_r && in_stop_r)
        else $error("shutdown stop woke without the reset pin");

    pin_wake_a: assert property (@(posedge mclk) disable iff (!nrst)
        (stop_off_s ##0 !rst_pin_n) |=> device_reset_r && !in_stop_r && drive_r.core_en)
        else $error("reset pin failed to wake shutdown stop");

    settle_count_a: assert property (@(posedge mclk) disable iff (!nrst)
        (!core_lp ##1 core_lp) |-> !osc_ok [*8] ##1 !osc_ok [*4])
        else $error("oscillator guard ready before twelve clocks");

    settle_ready_a: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(osc_ok) |-> $past(core_lp, 12))
        else $error("oscillator guard ready without twelve clocks");

    misuse_flag_a: assert property (@(posedge mclk) disable iff (!nrst)
        (wr_ctrl && writedata[1] && writedata[7]) |=> status_r[regulator_pkg::EV_MISUSE])
        else $error("core low power misuse not flagged");

    bus_answer_a: assert property (@(posedge mclk) disable iff (!nrst)
        (req && waitrequest_r) |=> !waitrequest_r ##1 waitrequest_r)
        else $error("bus answer not one cycle after request");

    irq_level_a: assert property (@(posedge mclk) disable iff (!nrst)
        irq_r == |(status_r & mask_r))
        else $error("interrupt output disagrees with status and mask");

endmodule

`default_nettype wire
